// ===== bid_interval_display.sv
/*
  decimal readout: bcd counter beside the coarse counter, end-of-conversion
  strobe chain, fine-word conversion and multiplexed twelve-digit display.
  assumes the partner's pulse, clear, end-of-conversion and fine word are
  synchronous to core_clk, coarse pulses are one cycle wide and the
  end-of-conversion level stays high until the next clear.
*/
`timescale 1ns/1ns
module bid_interval_display
    import bid_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // from the digitizer logic
    input wire logic coarse_pulse,
    input wire logic cnt_clear,
    input wire logic eoc,
    input bid_fine_t fine_in,
    // display
    output bid_disp_t disp,
    output logic scan_active
);
    logic [DEC_W-1:0] dec_q, dec_d;
    logic [NUM_STAGE-1:0] stage_q, stage_d;
    bid_fine_t fine_q, fine_d;
    logic [10:0] div_q, div_d;
    logic [10:0] scan_wait_q, scan_wait_d;
    logic [SCAN_LEN-1:0] scan_q, scan_d;
    logic zero_blank_latch_q, zero_blank_latch_d;
    bid_disp_t disp_q, disp_d;
    logic strobe_gate_first, strobe_gate_second, strobe_gate_third, strobe_gate_fourth;
    logic eoc_delay_first, eoc_delay_seventh, eoc_delay_final;
    logic count_merge_gate, ba_add, scan_tick, scan_feedback_gate;
    logic [1:0] inc_amt;
    logic [3:0] lowest_bcd_decade, highest_bcd_decade;
    bid_cvt_t cvt;
    logic [3:0] row_digit [2];
    logic row_blank [2];
    logic [6:0] row_seg [2];

    // add a small amount at the lowest decade and ripple decimal carries
    function automatic logic [DEC_W-1:0] bcd_add(input logic [DEC_W-1:0] v,
                                                 input logic [1:0] amt);
        logic [4:0] s;
        logic [1:0] c;
        logic [DEC_W-1:0] r;
        c = amt;
        r = v;
        for (int i = 0; i < NUM_DEC; i++)
        begin
            s = {1'b0, v[i*4 +: 4]} + {3'b000, c};
            if (s > 5'h09)
            begin
                s = s - 5'h0a;
                c = 2'h1;
            end
            else
                c = 2'h0;
            r[i*4 +: 4] = s[3:0];
        end
        // top decade only needs 0..3: range ends just below 400 ms
        r[DEC_W-1 -: 4] = {2'b00, r[DEC_W-3 -: 2] & TOP_DEC_MASK};
        return r;
    endfunction

    // pick the decade shown at scan position idx on row (1 = upper)
    function automatic logic [3:0] digit_sel(input logic [DEC_W-1:0] dv,
                                             input bid_cvt_t cv,
                                             input logic [SCAN_LEN-1:0] sc,
                                             input logic upper);
        logic [3:0] d;
        d = 4'h0;
        for (int i = 0; i < ROW_DIGITS; i++)
        begin
            if (sc[i])
            begin
                if (upper)
                    d = dv[(NUM_DEC-1-i)*4 +: 4];
                else if (i < 2)
                    d = dv[(1-i)*4 +: 4];
                else if (i == 2)
                    d = {3'b000, cv.converter_thousands_bit};
                else if (i == 3)
                    d = cv.hund;
                else if (i == 4)
                    d = cv.tens;
                else
                    d = cv.ones;
            end
        end
        return d;
    endfunction

    assign lowest_bcd_decade = dec_q[3:0];
    assign highest_bcd_decade = dec_q[DEC_W-1 -: 4];
    assign eoc_delay_first = stage_q[0];
    assign eoc_delay_seventh = stage_q[FINAL_STAGE-1];
    assign eoc_delay_final = stage_q[FINAL_STAGE];

    // strobe gates open on every second stage edge, one cycle each
    assign strobe_gate_first = stage_q[STB1_TAP] & ~stage_q[STB1_TAP+1];
    assign strobe_gate_second = stage_q[STB2_TAP] & ~stage_q[STB2_TAP+1];
    assign strobe_gate_third = stage_q[STB3_TAP] & ~stage_q[STB3_TAP+1];
    assign strobe_gate_fourth = eoc_delay_seventh & ~eoc_delay_final;

    // coarse pulses and the two-unit corrections share one input
    assign count_merge_gate = coarse_pulse
                            | (strobe_gate_second & fine_q.fine_weight_20ns_flag)
                            | (strobe_gate_third & fine_q.fine_weight_40ns_carry)
                            | (strobe_gate_fourth & fine_q.fine_weight_40ns_carry);
    // 10 ns bit goes straight into the first binary of the decade
    assign ba_add = strobe_gate_first & fine_q.adder[FINE_10NS_POS];
    // pulses land in the quinary half: +2 per pulse
    assign inc_amt = (count_merge_gate ? MERGE_INC : 2'h0) | (ba_add ? BA_INC : 2'h0);

    // counter group
    always_comb
    begin
        dec_d = dec_q;
        if (cnt_clear)
            dec_d = DEC_RST;
        else if (inc_amt != 2'h0)
            dec_d = bcd_add(dec_q, inc_amt);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            dec_q <= DEC_RST;
        else
            dec_q <= dec_d;
    end

    // delay chain and fine word group
    always_comb
    begin
        stage_d = {stage_q[NUM_STAGE-2:0], eoc};
        fine_d = fine_q;
        if (eoc && !stage_q[0])
            fine_d = fine_in;
        if (cnt_clear)
        begin
            stage_d = STAGE_RST;
            fine_d = '0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            stage_q <= STAGE_RST;
            fine_q <= '0;
        end
        else
        begin
            stage_q <= stage_d;
            fine_q <= fine_d;
        end
    end

    bid_bin2bcd u_cvt (
        .bin (fine_q.adder[CVT_W-1:0]),
        .bcd (cvt)
    );

    // scan group: free-running 10 kHz tick, shift register, blanking latch
    assign scan_tick = (div_q == SCAN_DIV_LAST);
    assign scan_feedback_gate = ~|scan_q[SCAN_LEN-2:0];
    assign scan_active = eoc_delay_final;

    always_comb
    begin
        div_d = scan_tick ? 11'h000 : div_q + 11'h001;
        scan_d = scan_q;
        zero_blank_latch_d = zero_blank_latch_q;
        // cycles spent waiting for the first tick; a counter keeps the check short
        scan_wait_d = 11'h000;
        if (!eoc_delay_final || cnt_clear)
        begin
            scan_d = SCAN_RST;
            zero_blank_latch_d = 1'b0;
        end
        else
        begin
            if (scan_q == SCAN_RST)
                scan_wait_d = scan_wait_q + 11'h001;
            if (scan_tick)
                scan_d = {scan_q[SCAN_LEN-2:0], scan_feedback_gate};
            if (scan_q[SCAN_LEN-1])
                zero_blank_latch_d = 1'b0;
            else if (|scan_q && digit_sel(dec_q, cvt, scan_q, 1'b1) != 4'h0)
                zero_blank_latch_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            div_q <= 11'h000;
            scan_wait_q <= 11'h000;
            scan_q <= SCAN_RST;
            zero_blank_latch_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            scan_wait_q <= scan_wait_d;
            scan_q <= scan_d;
            zero_blank_latch_q <= zero_blank_latch_d;
        end
    end

    // row 1 is upper, row 0 is lower
    always_comb
    begin
        row_digit[1] = digit_sel(dec_q, cvt, scan_q, 1'b1);
        row_digit[0] = digit_sel(dec_q, cvt, scan_q, 1'b0);
        // leading upper zeros stay dark until a nonzero digit passes
        row_blank[1] = ~eoc_delay_final | (row_digit[1] == 4'h0 & ~zero_blank_latch_q);
        // thousands place dark when the low group is 999 or less
        row_blank[0] = ~eoc_delay_final | (scan_q[2] & ~cvt.converter_thousands_bit);
    end

    generate
        for (genvar r = 0; r < 2; r++)
        begin : g_row
            bid_seg7 u_seg (
                .digit (row_digit[r]),
                .blank (row_blank[r]),
                .seg (row_seg[r])
            );
        end
    endgenerate

    // display group: registered so the pins never see decoder glitches
    always_comb
    begin
        disp_d.digit_en = eoc_delay_final ? scan_q[ROW_DIGITS-1:0] : '0;
        disp_d.seg_upper = row_seg[1];
        disp_d.seg_lower = row_seg[0];
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            disp_q <= '0;
        else
            disp_q <= disp_d;
    end

    assign disp = disp_q;

    // checks
    AST_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
        cnt_clear |=> dec_q == DEC_RST)
        else $error("bcd counter not cleared");

    AST_COARSE_TWO: assert property (@(posedge core_clk) disable iff (!rst_n)
        (coarse_pulse && !cnt_clear && !ba_add && lowest_bcd_decade < 4'h8)
        |=> lowest_bcd_decade == $past(lowest_bcd_decade) + 4'h2)
        else $error("coarse pulse did not add two");

    AST_TOP_RANGE: assert property (@(posedge core_clk) disable iff (!rst_n)
        highest_bcd_decade <= 4'h3)
        else $error("top decade above three");

    AST_STROBE_ONEHOT: assert property (@(posedge core_clk) disable iff (!rst_n)
        $onehot0({strobe_gate_first, strobe_gate_second, strobe_gate_third,
                  strobe_gate_fourth}))
        else $error("strobes overlap");

    AST_STROBE_SEQ: assert property (@(posedge core_clk) disable iff (!rst_n)
        (strobe_gate_first && !cnt_clear && eoc) |-> ##2 strobe_gate_second ##2
        strobe_gate_third ##2 strobe_gate_fourth ##1 eoc_delay_final)
        else $error("strobe sequence broken");

    AST_BA_ADD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (strobe_gate_first && fine_q.adder[FINE_10NS_POS] && !coarse_pulse
         && !cnt_clear && lowest_bcd_decade < 4'h9)
        |=> lowest_bcd_decade == $past(lowest_bcd_decade) + 4'h1)
        else $error("10 ns bit not added");

    AST_CARRY_ADD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (strobe_gate_third && fine_q.fine_weight_40ns_carry && !cnt_clear
         && lowest_bcd_decade < 4'h6)
        |=> ##2 lowest_bcd_decade == $past(lowest_bcd_decade, 3) + 4'h4)
        else $error("carry not added twice");

    AST_CONVERT: assert property (@(posedge core_clk) disable iff (!rst_n)
        int'(cvt.converter_thousands_bit) * 1000 + int'(cvt.hund) * 100
        + int'(cvt.tens) * 10 + int'(cvt.ones) == int'(fine_q.adder[CVT_W-1:0]))
        else $error("bcd conversion wrong");

    AST_SCAN_HELD: assert property (@(posedge core_clk) disable iff (!rst_n)
        !eoc_delay_final |=> disp_q.digit_en == '0 && disp_q.seg_upper == SEG_BLANK)
        else $error("display active before counting done");

    AST_SCAN_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (scan_tick && eoc_delay_final && !cnt_clear && scan_q[SCAN_LEN-1])
        |=> scan_q == 7'h01)
        else $error("scan sequence did not restart");

    AST_SCAN_START: assert property (@(posedge core_clk) disable iff (!rst_n)
        scan_wait_q <= SCAN_DIV_LAST + 11'h001)
        else $error("scan did not start");

    AST_DIGIT_EN: assert property (@(posedge core_clk) disable iff (!rst_n)
        $onehot0(disp_q.digit_en))
        else $error("more than one digit enabled");

    AST_LATCH_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
        (scan_q[SCAN_LEN-1] && eoc_delay_final && !cnt_clear) |=> !zero_blank_latch_q)
        else $error("blank latch not reset on seventh pulse");

    AST_THOUS_BLANK: assert property (@(posedge core_clk) disable iff (!rst_n)
        (scan_q[2] && !cvt.converter_thousands_bit) |=> disp_q.seg_lower == SEG_BLANK)
        else $error("thousands digit not blanked");

    AST_UPPER_SHOWN: assert property (@(posedge core_clk) disable iff (!rst_n)
        (eoc_delay_final && row_digit[1] != 4'h0)
        |=> disp_q.seg_upper != SEG_BLANK)
        else $error("nonzero top decade not shown");

    AST_LATCH_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
        (eoc_delay_final && !cnt_clear && row_digit[1] != 4'h0)
        |=> zero_blank_latch_q)
        else $error("blank latch not set on nonzero digit");
endmodule

// ===== bid_pkg.sv
/*
  constants, carrier types and segment table for the decimal interval readout.
  assumes a single 20 MHz core clock and a synchronous active-low reset.
*/
// Notes on behaviour
// - clear all eight bcd decades whenever the partner clears its counters
// - each coarse pulse adds two to the lowest decade, worth 10 ns per unit
// - top decade counts tenths of a second and wraps after 3
// - coarse pulses and the 20 ns and 40 ns end corrections enter through one merge gate
// - end of conversion runs through eight delay stages opening four strobes
// - strobes one and two add 10 ns bit and 20 ns flag to decade four
// - strobes three and four each add the 40 ns carry as two units
// - ten low fine bits convert combinationally to three decades plus one bit
// - eighth delay stage ends counting and lets the 10 kHz tick scan digits
// - scan register with feedback gate repeats a seven-pulse sequence
// - pulses one to six each enable one digit and route its decade
// - seventh pulse resets the upper row zero-blanking latch
// - upper row: decades eleven to six; lower: five, four, thousands bit, three to one
// - blank the fourth low digit when the low four digits are 999 or less
package bid_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int SCAN_HZ = 10_000;
    localparam int SCAN_DIV = CLK_HZ / SCAN_HZ;
    localparam logic [10:0] SCAN_DIV_LAST = 11'(SCAN_DIV - 1);
    localparam int NUM_DEC = 8;
    localparam int DEC_W = 4 * NUM_DEC;
    localparam logic [1:0] TOP_DEC_MASK = 2'h3;
    localparam int NUM_STAGE = 8;
    localparam int FINAL_STAGE = 7;
    localparam int STB1_TAP = 0;
    localparam int STB2_TAP = 2;
    localparam int STB3_TAP = 4;
    localparam int STB4_TAP = 6;
    localparam int FINE_W = 12;
    localparam int CVT_W = 10;
    localparam int FINE_10NS_POS = 10;
    localparam logic [1:0] MERGE_INC = 2'h2;
    localparam logic [1:0] BA_INC = 2'h1;
    localparam int SCAN_LEN = 7;
    localparam int ROW_DIGITS = 6;
    localparam logic [SCAN_LEN-1:0] SCAN_RST = 7'h00;
    localparam logic [DEC_W-1:0] DEC_RST = 32'h0000_0000;
    localparam logic [NUM_STAGE-1:0] STAGE_RST = 8'h00;
    localparam logic [6:0] SEG_BLANK = 7'h00;
    // segments a..g on bits 6..0, active high
    localparam logic [6:0] SEG_TABLE [10] = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33,
                                              7'h5b, 7'h5f, 7'h70, 7'h7f, 7'h7b};

    typedef struct packed {
        logic fine_weight_40ns_carry;
        logic fine_weight_20ns_flag;
        logic [FINE_W-1:0] adder;
    } bid_fine_t;

    typedef struct packed {
        logic converter_thousands_bit;
        logic [3:0] hund;
        logic [3:0] tens;
        logic [3:0] ones;
    } bid_cvt_t;

    typedef struct packed {
        logic [ROW_DIGITS-1:0] digit_en;
        logic [6:0] seg_upper;
        logic [6:0] seg_lower;
    } bid_disp_t;
endpackage

// ===== bid_bin2bcd.sv
/*
  combinational ten-bit binary to bcd converter for the interpolation word.
  assumes the input never exceeds 1023, so thousands is a single bit.
*/
`timescale 1ns/1ns
module bid_bin2bcd
    import bid_pkg::*;
(
    // binary in
    input wire logic [CVT_W-1:0] bin,
    // bcd out
    output bid_cvt_t bcd
);
    logic [25:0] sh;

    // shift-and-add-three, unrolled by the loop
    always_comb
    begin
        sh = {16'h0000, bin};
        for (int i = 0; i < CVT_W; i++)
        begin
            if (sh[13:10] > 4'h4)
                sh[13:10] = sh[13:10] + 4'h3;
            if (sh[17:14] > 4'h4)
                sh[17:14] = sh[17:14] + 4'h3;
            if (sh[21:18] > 4'h4)
                sh[21:18] = sh[21:18] + 4'h3;
            sh = {sh[24:0], 1'b0};
        end
        bcd.converter_thousands_bit = sh[22];
        bcd.hund = sh[21:18];
        bcd.tens = sh[17:14];
        bcd.ones = sh[13:10];
    end
endmodule

// ===== bid_seg7.sv
/*
  seven-segment decoder with blanking input.
  assumes active-high segments; codes above 9 show nothing.
*/
`timescale 1ns/1ns
module bid_seg7
    import bid_pkg::*;
(
    // digit in
    input wire logic [3:0] digit,
    input wire logic blank,
    // segments out
    output logic [6:0] seg
);
    always_comb
    begin
        if (blank || digit > 4'h9)
            seg = SEG_BLANK;
        else
            seg = SEG_TABLE[digit];
    end
endmodule

// ===== bid_digitizer_model.sv
/*
  behavioural model of the digitizer logic that feeds the decimal readout.
  assumes the bench calls its tasks and that core_clk is the readout's clock;
  every change is made at a falling edge.
*/
`timescale 1ns/1ns
module bid_digitizer_model
    import bid_pkg::*;
(
    // clock
    input wire logic core_clk,
    // toward the readout
    output logic coarse_pulse,
    output logic cnt_clear,
    output logic eoc,
    output bid_fine_t fine_in
);
    initial
    begin
        coarse_pulse = 1'b0;
        cnt_clear = 1'b0;
        eoc = 1'b0;
        fine_in = 14'h2aaa;
    end

    // counter clear also drops end of conversion, as the real logic does
    task automatic clear();
        @(negedge core_clk);
        cnt_clear = 1'b1;
        eoc = 1'b0;
        @(negedge core_clk);
        cnt_clear = 1'b0;
    endtask

    // one measurement: clear, n back-to-back pulses, gap idle cycles, then eoc
    task automatic measure(input int n, input int gap, input bid_fine_t f);
        fine_in = ~f;
        clear();
        repeat (n)
        begin
            coarse_pulse = 1'b1;
            @(negedge core_clk);
        end
        coarse_pulse = 1'b0;
        repeat (gap) @(negedge core_clk);
        eoc = 1'b1;
        fine_in = f;
        @(negedge core_clk);
        // word is only valid on the eoc edge; afterwards show something else
        fine_in = ~f;
    endtask
endmodule

// ===== bid_interval_display_tb_top.sv
/*
  self-checking bench for the decimal interval readout.
  assumes the digitizer model drives the partner side at falling edges
  and that the scan divider is the fixed 2000-cycle one.
*/
`timescale 1ns/1ns
module bid_interval_display_tb_top
    import bid_pkg::*;
;
    typedef struct {
        int n;
        int gap;
        bid_fine_t f;
        logic [31:0] dec;
        logic [12:0] cv;
    } bid_row_t;
    logic core_clk;
    logic rst_n;
    logic coarse_pulse;
    logic cnt_clear;
    logic eoc;
    bid_fine_t fine_in;
    bid_disp_t disp;
    logic scan_active;
    int err_count = 0;
    int checked = 0;
    bid_row_t rows [4];

    bid_interval_display i_bid_interval_display (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .coarse_pulse(coarse_pulse),
        .cnt_clear(cnt_clear),
        .eoc(eoc),
        .fine_in(fine_in),
        .disp(disp),
        .scan_active(scan_active)
    );

    bid_digitizer_model i_bid_digitizer_model (
        .core_clk(core_clk),
        .coarse_pulse(coarse_pulse),
        .cnt_clear(cnt_clear),
        .eoc(eoc),
        .fine_in(fine_in)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [6:0] seg_of(input logic [3:0] d, input logic blank);
        return blank ? SEG_BLANK : SEG_TABLE[d];
    endfunction

    // dec holds the counter decades, top first, cv the thousands bit and three low decades
    task automatic read_seq(input logic [31:0] dec, input logic [12:0] cv);
        int k;
        logic lat;
        logic [3:0] up;
        logic [3:0] lo [6];
        k = 0;
        lat = 1'b0;
        lo = '{dec[7:4], dec[3:0], {3'h0, cv[12]}, cv[11:8], cv[7:4], cv[3:0]};
        while (disp.digit_en !== 6'h01 && k < 4000)
        begin
            @(negedge core_clk);
            k++;
        end
        chk(k < 4000, 1'b1);
        for (int p = 0; p < 6; p++)
        begin
            up = dec[31 - 4 * p -: 4];
            if (up != 4'h0)
                lat = 1'b1;
            chk(disp.digit_en, 6'h01 << p);
            chk(disp.seg_upper, seg_of(up, !lat));
            chk(disp.seg_lower, seg_of(lo[p], p == 2 && !cv[12]));
            repeat (2000) @(negedge core_clk);
        end
        chk(disp.digit_en, 6'h00);
        k = 0;
        while (disp.digit_en !== 6'h01 && k < 2100)
        begin
            @(negedge core_clk);
            k++;
        end
        // latch must be clear again at the start of the next sequence
        chk(disp.seg_upper, seg_of(dec[31:28], dec[31:28] == 4'h0));
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever
            #25 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (90000) @(posedge core_clk);
        err_count++;
        $display("mismatch at %0t: run did not finish", $time);
        test_done();
    end

    initial
    begin
        rst_n = 1'b0;
        rows[0] = '{0, 1, 14'h0000, 32'h0000_0000, 13'h0000};
        rows[1] = '{3, 1, 14'h37ff, 32'h0000_0013, 13'h1023};
        rows[2] = '{5000, 1, 14'h23e7, 32'h0001_0004, 13'h0999};
        rows[3] = '{4, 50, 14'h1600, 32'h0000_0011, 13'h0512};
        repeat (20) @(negedge core_clk);
        chk({disp, scan_active}, 32'h0);
        rst_n = 1'b1;
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            i_bid_digitizer_model.measure(rows[i].n, rows[i].gap, rows[i].f);
            repeat (6) @(negedge core_clk);
            chk({disp, scan_active}, 32'h0);
            @(negedge core_clk);
            chk(scan_active, 1'b1);
            read_seq(rows[i].dec, rows[i].cv);
            $display("test row %0d done", i);
        end
        // clear arrives while digits are being scanned
        i_bid_digitizer_model.clear();
        @(negedge core_clk);
        chk({disp, scan_active}, 32'h0);
        $display("test clear while scanning done");
        // reset in mid-run darkens everything at once
        i_bid_digitizer_model.measure(7, 1, 14'h0000);
        repeat (9) @(negedge core_clk);
        chk(scan_active, 1'b1);
        rst_n = 1'b0;
        @(negedge core_clk);
        chk({disp, scan_active}, 32'h0);
        rst_n = 1'b1;
        $display("test mid-run reset done");
        test_done();
    end
endmodule
